// File: logic/ptm_pkg.sv
// Package: register map, field positions and mode codes of the period timer
package ptm_pkg;

    // ****************************************************************
    // Register byte offsets on the bus
    // ****************************************************************
    localparam logic [7:0] PTM_OFS_COUNT   = 8'h00;
    localparam logic [7:0] PTM_OFS_PERIOD  = 8'h04;
    localparam logic [7:0] PTM_OFS_CONTROL = 8'h08;
    localparam logic [7:0] PTM_OFS_HLIMIT  = 8'h0c;
    localparam logic [7:0] PTM_OFS_CLKSEL  = 8'h10;
    localparam logic [7:0] PTM_OFS_RSTSEL  = 8'h14;
    localparam logic [7:0] PTM_OFS_STATUS  = 8'h18;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int PTM_CTL_ON      = 7;
    localparam int PTM_CTL_PS_LSB  = 4;
    localparam int PTM_HLT_PRESCALER_SYNC_BIT   = 7;
    localparam int PTM_HLT_CKPOL   = 6;
    localparam logic [7:0] PTM_PERIOD_RST = 8'hff;
    localparam logic [7:0] PTM_ZERO8      = 8'h00;

    // ****************************************************************
    // Clock select codes
    // ****************************************************************
    localparam logic [3:0] PTM_CS_INSTR = 4'h1;
    localparam logic [3:0] PTM_CS_SYS   = 4'h2;
    localparam logic [3:0] PTM_CS_HFOSC = 4'h3;
    localparam logic [3:0] PTM_CS_LFOSC = 4'h4;
    localparam logic [3:0] PTM_CS_MFOSC = 4'h5;
    localparam logic [3:0] PTM_CS_LAST  = 4'hb;

    // ****************************************************************
    // Operating mode codes of the one-shot gating modes
    // ****************************************************************
    localparam logic [4:0] PTM_MD_LVL_LO  = 5'h0e;
    localparam logic [4:0] PTM_MD_LVL_HI  = 5'h0f;
    localparam logic [4:0] PTM_MD_MONO_R  = 5'h11;
    localparam logic [4:0] PTM_MD_MONO_F  = 5'h12;
    localparam logic [4:0] PTM_MD_MONO_RF = 5'h13;
    localparam logic [4:0] PTM_MD_HL_LO   = 5'h16;
    localparam logic [4:0] PTM_MD_HL_HI   = 5'h17;

    // AHB transfer size of a whole word
    localparam logic [2:0] PTM_HSIZE_WORD = 3'h2;

endpackage

// File: logic/ptm_timer.sv
// Module: 8-bit period timer with one-shot gating modes and AHB-Lite slave
`timescale 1ns/1ns

// Summary of operation
// R1: Level one-shot: hold clear, start on leaving
// R2: Level one-shot match clears count and run
// R3: Level one-shot drive set on start edge only
// R4: Monostable: start on edge, stop at match
// R5: Monostable: later edges leave drive alone
// R6: Hardware-limit one-shot: run when on, released
// R7: Hardware-limit match clears run; stay in reset
// R8: Hardware-limit drive set on whichever starts
// R9: Period register double-buffered, buffer hidden
// R10: Buffer loads on count and control writes, match, reset event
// R11: Sync prescaler stops timer during sleep
// R12: Async prescaler runs in sleep; keeps oscillator
// R13: Four-bit clock select picks the source
// R14: Clock select upper four bits read zero
// R15: Run bit off resets prescaler and state
// R16: Prescale divides by two to field power
// R17: Postscale ratio is field plus one
// R18: Five-bit mode field picks operating mode
// R19: Count clears on clock after period match
// R20: Five-bit reset select picks external source
// R21: Flag raised after selected number of matches
// R22: External signal synchronised before edge detection
module ptm_timer
(
    input  wire logic        mclk,              // System clock, 50 MHz
    input  wire logic        resetn,            // Async reset, active low
    input  wire logic        hsel,              // AHB slave select
    input  wire logic [7:0]  haddr,             // AHB byte address
    input  wire logic [1:0]  htrans,            // AHB transfer type
    input  wire logic        hwrite,            // AHB write
    input  wire logic [2:0]  hsize,             // AHB size
    input  wire logic [31:0] hwdata,            // AHB write data
    input  wire logic        hready,            // AHB bus ready
    output logic             hreadyout,         // Slave ready, always high
    output logic             hresp,             // Slave response, OKAY
    output logic [31:0]      hrdata,            // Read data
    input  wire logic [11:0] clk_src_lvl,       // Clock source levels
    input  wire logic [31:0] ers_src_lvl,       // External reset sources
    input  wire logic [7:0]  pulse_width_value, // Compare module duty
    input  wire logic        sleep_req,         // Processor asleep
    output logic             pwm_drive,         // Drive to compare module
    output logic             period_match,      // Period match pulse
    output logic             postscaled_pulse,  // Postscaled match pulse
    output logic             keep_hf_osc,       // Keep high osc in sleep
    output logic             keep_lf_osc,       // Keep low osc in sleep
    output logic             keep_mf_osc        // Keep mid osc in sleep
);
    import ptm_pkg::*;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0]  count_r;
    logic [7:0]  period_r;
    logic [7:0]  pbuf_r;
    logic        on_r;
    logic [2:0]  ckps_r;
    logic [3:0]  outps_r;
    logic [7:0]  hlt_r;
    logic [3:0]  cs_r;
    logic [4:0]  rsel_r;
    logic        flag_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [6:0]  presc_r;
    logic [3:0]  post_r;
    logic        run_r;
    logic        hl_run_d_r;
    logic        pwm_r;
    logic        match_pulse_r;
    logic        post_pulse_r;
    logic [2:0]  keep_r;
    logic [1:0]  div4_r;
    logic        src_s1_r;
    logic        src_s2_r;
    logic        src_d_r;
    logic        ers_s1_r;
    logic        ers_s2_r;
    logic        ers_d_r;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic addr_ph;
    logic wr_ok;
    logic cnt_wr;
    logic per_wr;
    logic ctl_wr;
    logic hlt_wr;
    logic cs_wr;
    logic rs_wr;
    logic st_wr;

    // Address phase taken on a valid, selected transfer; writes kept only at word size
    assign addr_ph = hsel && hready && htrans[1];
    assign wr_ok   = wr_pend_r;
    assign cnt_wr  = wr_ok && (wr_addr_r == PTM_OFS_COUNT);
    assign per_wr  = wr_ok && (wr_addr_r == PTM_OFS_PERIOD);
    assign ctl_wr  = wr_ok && (wr_addr_r == PTM_OFS_CONTROL);
    assign hlt_wr  = wr_ok && (wr_addr_r == PTM_OFS_HLIMIT);
    assign cs_wr   = wr_ok && (wr_addr_r == PTM_OFS_CLKSEL);
    assign rs_wr   = wr_ok && (wr_addr_r == PTM_OFS_RSTSEL);
    assign st_wr   = wr_ok && (wr_addr_r == PTM_OFS_STATUS);

    // Zero wait states and always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_r;

    // Write address captured for the data phase
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end
        else
        begin
            wr_pend_r <= addr_ph && hwrite && (hsize == PTM_HSIZE_WORD);
            wr_addr_r <= haddr;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        unique case (haddr)
            PTM_OFS_COUNT:   rdata_nxt[7:0] = count_r;
            PTM_OFS_PERIOD:  rdata_nxt[7:0] = period_r;          // R9
            PTM_OFS_CONTROL: rdata_nxt[7:0] = {on_r, ckps_r, outps_r};
            PTM_OFS_HLIMIT:  rdata_nxt[7:0] = hlt_r;
            PTM_OFS_CLKSEL:  rdata_nxt[7:0] = {4'h0, cs_r};      // R14
            PTM_OFS_RSTSEL:  rdata_nxt[7:0] = {3'h0, rsel_r};
            PTM_OFS_STATUS:  rdata_nxt[7:0] = {pwm_r, run_r, 5'h00, flag_r};
            default:         rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Read data registered for the data phase
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rdata_r <= 32'h0000_0000;
        else if (addr_ph && !hwrite)
            rdata_r <= rdata_nxt;
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            period_r <= PTM_PERIOD_RST;
            ckps_r   <= 3'h0;
            outps_r  <= 4'h0;
            hlt_r    <= 8'h00;
            cs_r     <= 4'h0;
            rsel_r   <= 5'h00;
        end
        else
        begin
            if (per_wr)
                period_r <= hwdata[7:0];
            if (ctl_wr)
                ckps_r <= hwdata[6:4];                           // R16
            if (ctl_wr)
                outps_r <= hwdata[3:0];                          // R17
            if (hlt_wr)
                hlt_r <= hwdata[7:0];                            // R18
            if (cs_wr)
                cs_r <= hwdata[3:0];                             // R13
            if (rs_wr)
                rsel_r <= hwdata[4:0];                           // R20
        end
    end

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    logic [4:0] mode;
    logic       prescaler_sync_bit;
    logic       is_lvl;
    logic       is_mono;
    logic       is_hl;
    logic       is_sw;
    logic       rst_lvl;

    assign mode    = hlt_r[4:0];
    assign prescaler_sync_bit   = hlt_r[PTM_HLT_PRESCALER_SYNC_BIT];
    assign is_lvl  = (mode == PTM_MD_LVL_LO) || (mode == PTM_MD_LVL_HI);
    assign is_mono = (mode == PTM_MD_MONO_R) || (mode == PTM_MD_MONO_F)
                  || (mode == PTM_MD_MONO_RF);
    assign is_hl   = (mode == PTM_MD_HL_LO) || (mode == PTM_MD_HL_HI);
    assign is_sw   = !(is_lvl || is_mono || is_hl);
    assign rst_lvl = mode[0];                    // Odd codes reset high

    // ****************************************************************
    // Clock source and external reset synchronisers
    // ****************************************************************
    logic src_mux;
    logic ers_mux;

    // Pin-level clock sources; internal clocks handled below
    assign src_mux = (cs_r <= PTM_CS_LAST) ? clk_src_lvl[cs_r] : 1'b0;
    assign ers_mux = ers_src_lvl[rsel_r];

    // Two flip-flops, then an edge-detect stage
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            src_s1_r <= 1'b0;
            src_s2_r <= 1'b0;
            src_d_r  <= 1'b0;
            ers_s1_r <= 1'b0;
            ers_s2_r <= 1'b0;
            ers_d_r  <= 1'b0;
        end
        else
        begin
            src_s1_r <= src_mux;
            src_s2_r <= src_s1_r;
            src_d_r  <= src_s2_r;
            ers_s1_r <= ers_mux;                                 // R22
            ers_s2_r <= ers_s1_r;
            ers_d_r  <= ers_s2_r;
        end
    end

    // Instruction clock divider
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            div4_r <= 2'h0;
        else
            div4_r <= div4_r + 2'h1;
    end

    // ****************************************************************
    // Timer ticks, prescaler and gating
    // ****************************************************************
    logic src_tick;
    logic tick;
    logic roll;
    logic match;
    logic in_reset;
    logic leave_rst;
    logic sel_edge;
    logic start_ev;
    logic hl_run;
    logic cnt_en;
    logic inc;
    logic hold_clr;
    logic os_clr;
    logic ers_evt;
    logic pwm_start;
    logic [6:0] ps_mask;

    // Selected input edge, polarity from the clock polarity bit
    always_comb
    begin
        src_tick = 1'b0;
        if (cs_r == PTM_CS_SYS)
            src_tick = 1'b1;
        else if (cs_r == PTM_CS_INSTR)
            src_tick = (div4_r == 2'h3);
        else if (hlt_r[PTM_HLT_CKPOL])
            src_tick = !src_s2_r && src_d_r;
        else
            src_tick = src_s2_r && !src_d_r;
    end

    assign tick      = src_tick && on_r && !(sleep_req && prescaler_sync_bit); // R11
    assign ps_mask   = 7'((8'h01 << ckps_r) - 8'h01);
    assign roll      = tick && ((presc_r & ps_mask) == ps_mask); // R16
    assign match     = (count_r == pbuf_r);
    assign in_reset  = (ers_s2_r == rst_lvl);
    assign leave_rst = (ers_d_r == rst_lvl) && !in_reset;
    assign hl_run    = on_r && !in_reset;                        // R6
    assign sel_edge  = (mode[0] && ers_s2_r && !ers_d_r)
                    || (mode[1] && !ers_s2_r && ers_d_r);
    assign start_ev  = on_r && !run_r
                    && ((is_lvl && leave_rst) || (is_mono && sel_edge));
    assign cnt_en    = is_sw ? on_r :
                       is_hl ? hl_run :
                       is_lvl ? (run_r && !in_reset) : run_r;
    assign inc       = cnt_en && roll;
    assign hold_clr  = (is_lvl && in_reset)                      // R1
                    || (is_hl && !hl_run);                       // R7
    assign os_clr    = inc && match && (is_lvl || is_hl);        // R2
    assign ers_evt   = start_ev || ((is_lvl || is_hl) && in_reset);
    assign pwm_start = start_ev                                  // R5
                    || (is_hl && hl_run && !hl_run_d_r)          // R8
                    || (is_sw && inc && match);

    // Prescaler counts source edges; cleared while off
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            presc_r <= 7'h00;
        else if (!on_r || ctl_wr || cnt_wr)
            presc_r <= 7'h00;                                    // R15
        else if (tick)
            presc_r <= roll ? 7'h00 : presc_r + 7'h01;
    end

    // Run bit: software writes, one-shot match clears
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            on_r <= 1'b0;
        else if (ctl_wr)
            on_r <= hwdata[PTM_CTL_ON];
        else if (os_clr)
            on_r <= 1'b0;                                        // R2
    end

    // Started state of the edge-started modes
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            run_r <= 1'b0;
        else if (!on_r)
            run_r <= 1'b0;                                       // R15
        else if (start_ev)
            run_r <= 1'b1;                                       // R4
        else if (inc && match && (is_mono || is_lvl))
            run_r <= 1'b0;                                       // R4
    end

    // Count: write, held clear, or increment and wrap at match
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            count_r <= PTM_ZERO8;
        else if (cnt_wr)
            count_r <= hwdata[7:0];
        else if (hold_clr)
            count_r <= PTM_ZERO8;                                // R6
        else if (inc)
            count_r <= match ? PTM_ZERO8 : count_r + 8'h01;      // R19
    end

    // Hidden period buffer reloads
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            pbuf_r <= PTM_PERIOD_RST;
        else if (cnt_wr || ctl_wr || (roll && match) || ers_evt)
            pbuf_r <= period_r;                                  // R10
    end

    // Drive to compare module; start wins over duty match
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            pwm_r      <= 1'b0;
            hl_run_d_r <= 1'b0;
        end
        else
        begin
            hl_run_d_r <= hl_run;
            if (pwm_start)
                pwm_r <= 1'b1;                                   // R3
            else if (count_r == pulse_width_value)
                pwm_r <= 1'b0;                                   // R3
        end
    end

    // Postscaler and sticky flag; set wins over clear
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            post_r        <= 4'h0;
            post_pulse_r  <= 1'b0;
            match_pulse_r <= 1'b0;
            flag_r        <= 1'b0;
        end
        else
        begin
            match_pulse_r <= inc && match;
            post_pulse_r  <= inc && match && (post_r == outps_r);
            if (!on_r)
                post_r <= 4'h0;                                  // R15
            else if (inc && match)
                post_r <= (post_r == outps_r) ? 4'h0 : post_r + 4'h1;
            if (inc && match && (post_r == outps_r))
                flag_r <= 1'b1;                                  // R21
            else if (st_wr && hwdata[0])
                flag_r <= 1'b0;
        end
    end

    // Oscillator keep-alive requests while asleep
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            keep_r <= 3'h0;
        else
        begin
            keep_r[0] <= sleep_req && !prescaler_sync_bit && (cs_r == PTM_CS_HFOSC);
            keep_r[1] <= sleep_req && !prescaler_sync_bit && (cs_r == PTM_CS_LFOSC);
            keep_r[2] <= sleep_req && !prescaler_sync_bit && (cs_r == PTM_CS_MFOSC);
        end
    end

    assign pwm_drive        = pwm_r;
    assign period_match     = match_pulse_r;
    assign postscaled_pulse = post_pulse_r;
    assign keep_hf_osc      = keep_r[0];                         // R12
    assign keep_lf_osc      = keep_r[1];
    assign keep_mf_osc      = keep_r[2];

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    chk_lvl_hold: assert property (is_lvl && in_reset && !cnt_wr // R1
        |=> count_r == 8'h00) else $error("count not held in reset");
    chk_os_clear: assert property (os_clr && !ctl_wr && !cnt_wr // R2
        |=> !on_r && count_r == 8'h00) else $error("one-shot not ended");
    chk_pwm_duty: assert property (pwm_r && !pwm_start // R3
        && count_r == pulse_width_value |=> !pwm_r)
        else $error("drive not released at duty");
    chk_mono_stop: assert property (is_mono && inc && match && on_r // R4
        && !cnt_wr && !hold_clr |=> !run_r ##0 count_r == 8'h00)
        else $error("monostable did not stop");
    chk_mono_edge: assert property (is_mono && run_r && !pwm_r // R5
        |=> !pwm_r) else $error("drive set by later edge");
    chk_hl_reset: assert property (is_hl && !hl_run && !cnt_wr // R7
        |=> count_r == 8'h00) else $error("limit mode not in reset");
    chk_hl_start: assert property (is_hl && $rose(hl_run) // R8
        |=> pwm_r) else $error("drive not set at limit start");
    chk_buf_load: assert property (ctl_wr // R10
        |=> pbuf_r == $past(period_r)) else $error("buffer not reloaded");
    chk_sleep_hold: assert property (sleep_req && prescaler_sync_bit && !wr_ok // R11
        && !hold_clr |=> $stable(count_r)) else $error("ran in sleep");
    chk_cs_read: assert property (addr_ph && !hwrite // R14
        && haddr == PTM_OFS_CLKSEL |=> hrdata[7:4] == 4'h0)
        else $error("clock select upper bits set");
    chk_post_flag: assert property (post_pulse_r |-> flag_r) // R21
        else $error("flag not raised");

    cov_lvl_run: cover property (is_lvl && start_ev ##[1:300] os_clr);
    cov_mono_run: cover property (is_mono && start_ev);
    cov_hl_run: cover property (is_hl && $rose(hl_run) ##1 pwm_r);
    cov_post: cover property (post_pulse_r && outps_r != 4'h0);

endmodule

// File: tb/ptm_far_end.sv
// Far-side model: external reset source, duty compare and clock sources
`timescale 1ns/1ns

module ptm_far_end
#(
    parameter logic [7:0] PW = 8'h03  // Duty compare value
)
(
    input  wire logic   mclk,              // System clock
    input  wire logic   ers_level,         // Chosen reset source level
    output logic [31:0] ers_src_lvl,       // Reset source lines
    output logic [7:0]  pulse_width_value, // Duty compare value
    output logic [11:0] clk_src_lvl        // Clock source levels
);
    logic div_r = 1'b0;  // Slow clock for the external sources

    // Every reset source follows the level the bench chooses
    assign ers_src_lvl       = {32{ers_level}};
    assign pulse_width_value = PW;
    assign clk_src_lvl       = {12{div_r}};

    // Halve the system clock so external sources really toggle
    always_ff @(posedge mclk)
    begin
        div_r <= !div_r;
    end
endmodule

// File: tb/period_timer_oneshot_modes_tb.sv
// Testbench: register access and one-shot gating modes of the period timer
`timescale 1ns/1ns

module period_timer_oneshot_modes_tb;
    import ptm_pkg::*;

    typedef struct packed
    {
        logic [7:0]  a;
        logic [31:0] w;
        logic [31:0] e;
    } ptm_row_t;

    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = PTM_HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [11:0] clk_src_lvl;
    logic [31:0] ers_src_lvl;
    logic [7:0]  pulse_width_value;
    logic        pwm_drive;
    logic        period_match;
    logic        ers_level = 1'b0;
    logic        sleep_req = 1'b0;
    logic        postscaled_pulse;
    logic [2:0]  keep;
    logic [31:0] q;
    ptm_row_t    rows [6];
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          i;

    // ****************************************************************
    // Clock, bus ready and instances
    // ****************************************************************
    always #10 mclk = !mclk;
    assign hready = hreadyout;

    ptm_timer dut (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .clk_src_lvl(clk_src_lvl),
        .ers_src_lvl(ers_src_lvl), .pulse_width_value(pulse_width_value),
        .sleep_req(sleep_req), .pwm_drive(pwm_drive),
        .period_match(period_match), .postscaled_pulse(postscaled_pulse),
        .keep_hf_osc(keep[0]), .keep_lf_osc(keep[1]), .keep_mf_osc(keep[2]));

    ptm_far_end far (.mclk(mclk), .ers_level(ers_level),
        .ers_src_lvl(ers_src_lvl), .pulse_width_value(pulse_width_value),
        .clk_src_lvl(clk_src_lvl));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input string n, input logic [31:0] s,
                         input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    // One single AHB transfer, address phase then data phase
    task automatic xfer(input logic [7:0] a, input logic wr,
                        input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    // Wait a bounded time for the drive to reach a level
    task automatic wait_pwm(input logic lvl);
        for (int k = 0; k < 40 && pwm_drive !== lvl; k++) @(posedge mclk);
    endtask

    task automatic wait_match;
        for (int k = 0; k < 60 && period_match !== 1'b1; k++)
            @(posedge mclk);
        check("match", {30'h0, postscaled_pulse, period_match}, 32'h3);
        @(posedge mclk);
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Cut a hang short
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            conclude();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        rows[0] = '{PTM_OFS_CLKSEL, 32'hff, 32'h0f};
        rows[1] = '{PTM_OFS_RSTSEL, 32'hff, 32'h1f};
        rows[2] = '{PTM_OFS_HLIMIT, 32'h0e, 32'h0e};
        rows[3] = '{PTM_OFS_PERIOD, 32'h05, 32'h05};
        rows[4] = '{8'h1c, 32'hff, 32'h00};
        rows[5] = '{PTM_OFS_CLKSEL, 32'h02, 32'h02};
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        xfer(PTM_OFS_PERIOD, 1'b0, 32'h0);
        check("period reset", q, 32'h000000ff);
        check("bus answer", {30'h0, hreadyout, hresp}, 32'h2);
        xfer(PTM_OFS_CONTROL, 1'b0, 32'h0);
        check("control reset", q, 32'h0);
        for (i = 0; i < 6; i++)
        begin
            xfer(rows[i].a, 1'b1, rows[i].w);
            xfer(rows[i].a, 1'b0, 32'h0);
            check("register row", q, rows[i].e);
        end
        // Level one-shot: held clear at low level, starts on rising edge
        xfer(PTM_OFS_RSTSEL, 1'b1, 32'h0);
        xfer(PTM_OFS_CONTROL, 1'b1, 32'h80);
        repeat (10) @(posedge mclk);
        xfer(PTM_OFS_COUNT, 1'b0, 32'h0);
        check("held count", q, 32'h0);
        ers_level <= 1'b1;
        wait_pwm(1'b1);
        check("drive on edge", {31'h0, pwm_drive}, 32'h1);
        wait_match();
        check("drive after match", {31'h0, pwm_drive}, 32'h0);
        xfer(PTM_OFS_CONTROL, 1'b0, 32'h0);
        check("run cleared", q, 32'h0);
        xfer(PTM_OFS_CONTROL, 1'b1, 32'h80);
        repeat (10) @(posedge mclk);
        xfer(PTM_OFS_COUNT, 1'b0, 32'h0);
        check("no fresh edge", q, 32'h0);
        // Monostable on rising edge keeps the run bit at match
        ers_level <= 1'b0;
        xfer(PTM_OFS_HLIMIT, 1'b1, {27'h0, PTM_MD_MONO_R});
        xfer(PTM_OFS_CONTROL, 1'b1, 32'h80);
        ers_level <= 1'b1;
        wait_pwm(1'b1);
        check("mono drive", {31'h0, pwm_drive}, 32'h1);
        ers_level <= 1'b0;
        wait_match();
        xfer(PTM_OFS_CONTROL, 1'b0, 32'h0);
        check("mono run kept", q, 32'h80);
        check("mono drive off", {31'h0, pwm_drive}, 32'h0);
        xfer(PTM_OFS_CONTROL, 1'b1, 32'h0);
        // Hardware-limit one-shot started by the run bit
        ers_level <= 1'b1;
        xfer(PTM_OFS_HLIMIT, 1'b1, {27'h0, PTM_MD_HL_LO});
        xfer(PTM_OFS_CONTROL, 1'b1, 32'h80);
        wait_pwm(1'b1);
        check("limit drive", {31'h0, pwm_drive}, 32'h1);
        wait_match();
        xfer(PTM_OFS_CONTROL, 1'b0, 32'h0);
        check("limit run cleared", q, 32'h0);
        ers_level <= 1'b0;
        xfer(PTM_OFS_CONTROL, 1'b1, 32'h80);
        repeat (10) @(posedge mclk);
        xfer(PTM_OFS_COUNT, 1'b0, 32'h0);
        check("limit held", q, 32'h0);
        // Synchronised prescaler freezes a software-gated count in sleep
        sleep_req <= 1'b1;
        xfer(PTM_OFS_HLIMIT, 1'b1, 32'h80);
        xfer(PTM_OFS_COUNT, 1'b1, 32'h2);
        repeat (10) @(posedge mclk);
        xfer(PTM_OFS_COUNT, 1'b0, 32'h0);
        check("sleep count", q, 32'h2);
        // Free-running prescaler in sleep keeps the high oscillator alive
        xfer(PTM_OFS_HLIMIT, 1'b1, 32'h0);
        xfer(PTM_OFS_CLKSEL, 1'b1, {28'h0, PTM_CS_HFOSC});
        repeat (2) @(posedge mclk);
        check("keep osc", {29'h0, keep}, 32'h1);
        // Reset in mid-run clears outputs and restores the period
        resetn <= 1'b0;
        @(posedge mclk);
        check("reset outputs", {28'h0, keep, pwm_drive}, 32'h0);
        resetn <= 1'b1;
        xfer(PTM_OFS_PERIOD, 1'b0, 32'h0);
        check("period after reset", q, 32'h000000ff);
        conclude();
    end
endmodule
